// file: design/pmc_ctrl.sv
// Power mode, clock source and reset cause controller
`timescale 1ns/1ns
`include "pmc_map.svh"

// How it works
// - Debug port boots two-pin, four-pin on request
// - Active: CPU, memories, radio, peripherals up
// - Idle: CPU and memory clocks stop; interrupt wakes
// - Idle to running CPU within fourteen microseconds
// - Standby wakes on pin, timer or coprocessor
// - Standby exit resumes CPU, retention kept
// - Standby holds all general I/O latched
// - Shutdown: everything off, only pin latch kept
// - Shutdown wake pin change causes a reset
// - Reset cause tells pin wake, pin, power-on
// - Wake sources allowed per mode
// - Clock enables per mode
// - Crystal sources high clock when enabled
// - Low RC clock needs tick compensation
// - Low clock external in, or driven out
// - Network role host link over SPI or UART
// - CPU may take coprocessor peripherals directly
module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int NPIN = 8
)
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Software mode request
  input wire logic mode_req,
  input wire pmc_mode_t mode_req_sel,
  // Wake sources
  input wire logic irq_event,
  input wire logic rtc_event,
  input wire logic sc_event,
  input wire logic reset_pin_n,
  input wire logic [NPIN-1:0] wake_pin,
  input wire logic [NPIN-1:0] pin_wake_en,
  input wire logic [NPIN-1:0] shut_wake_en,
  // General I/O drive from the core
  input wire logic [NPIN-1:0] gpio_out,
  // Configuration
  input wire logic jtag_cfg_wr,
  input wire logic jtag_4pin_sel,
  input wire logic hf_xtal_en,
  input wire logic lf_xtal_use,
  input wire logic lf_ext_sel,
  input wire logic lf_clk_out_req,
  input wire logic network_coprocessor_role,
  input wire logic host_uart_sel,
  input wire logic cpu_sc_take,
  // Mode status and handshake
  output pmc_mode_t cur_mode,
  output logic mode_ack,
  output logic cpu_resume,
  output logic sys_reset,
  output pmc_cause_t reset_cause,
  // Domain gating
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic flash_on,
  output logic sram_on,
  output logic sram_ret,
  output logic radio_avail,
  output logic periph_clk_en,
  output logic always_on_domain,
  output logic sc_on,
  // Clock control
  output logic high_speed_sys_clock,
  output logic hf_src_xtal,
  output logic medium_speed_sys_clock,
  output logic low_speed_sys_clock,
  output pmc_lf_src_t lf_src,
  output logic rtc_comp_en,
  output logic lf_clk_out_en,
  // Pads, debug, host and coprocessor
  output logic io_latch,
  output logic [NPIN-1:0] pad_out,
  output logic jtag_4pin,
  output logic host_spi_en,
  output logic host_uart_en,
  output logic sc_periph_by_cpu
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    pmc_mode_t mode;
    pmc_mode_t target;
    logic [`PMC_CNT_W-1:0] cnt;
    logic from_stby;
    logic [NPIN-1:0] pin_prev;
    logic [NPIN-1:0] hold_val;
    logic mode_ack;
    logic cpu_resume;
    logic sys_reset;
    pmc_cause_t cause;
    logic cpu_clk_en;
    logic mem_clk_en;
    logic flash_on;
    logic sram_on;
    logic sram_ret;
    logic radio_avail;
    logic periph_clk_en;
    logic aon_on;
    logic sc_on;
    logic hf_on;
    logic hf_xtal;
    logic mf_on;
    logic lf_on;
    pmc_lf_src_t lf_src;
    logic rtc_comp;
    logic lf_out;
    logic io_latch;
    logic [NPIN-1:0] pad;
    logic jtag_4pin;
    logic host_spi;
    logic host_uart;
    logic sc_by_cpu;
  } pmc_st_t;

  pmc_st_t s;
  pmc_st_t next_s;

  // ********************************
  // Input synchronisers
  // ********************************
  logic [NPIN+2:0] sync_q;
  logic [NPIN-1:0] pin_now;
  logic rtc_s;
  logic sc_s;
  logic rstpin_n_s;

  // Reset pin idles high so the sync stages start high too
  pmc_sync #(
    .W(NPIN + 3),
    .RST_VAL({1'b1, {(NPIN + 2){1'b0}}})
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in({reset_pin_n, sc_event, rtc_event, wake_pin}),
    .sync_out(sync_q)
  );

  assign pin_now = sync_q[NPIN-1:0];
  assign rtc_s = sync_q[NPIN];
  assign sc_s = sync_q[NPIN+1];
  assign rstpin_n_s = sync_q[NPIN+2];

  // ********************************
  // Helpers
  // ********************************
  // Only the low-power modes may be requested
  function automatic logic is_low_mode(input pmc_mode_t m);
    return (m == PMC_IDLE) || (m == PMC_STANDBY) ||
           (m == PMC_SHUTDOWN) || (m == PMC_HELD);
  endfunction : is_low_mode

  // Pin level change against a reference
  function automatic logic pin_hit(input logic [NPIN-1:0] now,
                                   input logic [NPIN-1:0] ref_lvl,
                                   input logic [NPIN-1:0] en);
    return |((now ^ ref_lvl) & en);
  endfunction : pin_hit

  // ********************************
  // Next state
  // ********************************
  logic edge_wake;
  logic lf_run;

  always_comb
  begin
    next_s = s;
    next_s.mode_ack = 1'b0;
    next_s.cpu_resume = 1'b0;
    next_s.sys_reset = 1'b0;
    next_s.pin_prev = pin_now;
    edge_wake = pin_hit(pin_now, s.pin_prev, pin_wake_en);
    lf_run = 1'b0;

    // Mode sequencing
    case (s.mode)
      PMC_ACTIVE:
      begin
        if (mode_req && is_low_mode(mode_req_sel))
        begin
          next_s.mode = PMC_ENTER;
          next_s.target = mode_req_sel;
          next_s.cnt = `PMC_GATE_CYC;
          next_s.hold_val = gpio_out;
        end
        if (jtag_cfg_wr)
          next_s.jtag_4pin = jtag_4pin_sel;
      end
      PMC_ENTER:
      begin
        // Ack only once clock gating has settled; domains power down on the ack edge
        if (s.cnt == `PMC_CNT_DONE)
        begin
          next_s.mode = s.target;
          next_s.mode_ack = 1'b1;
        end
        else
          next_s.cnt = s.cnt - 8'h01;
      end
      PMC_IDLE:
      begin
        if (irq_event || edge_wake || rtc_s)
        begin
          next_s.mode = PMC_WAKE;
          next_s.cnt = `PMC_RESTART_CYC;
        end
      end
      PMC_STANDBY:
      begin
        if (edge_wake || rtc_s || sc_s)
        begin
          next_s.mode = PMC_WAKE;
          next_s.cnt = `PMC_RESTART_CYC;
          next_s.from_stby = 1'b1;
        end
      end
      PMC_WAKE:
      begin
        if (s.cnt == `PMC_CNT_DONE)
        begin
          next_s.mode = PMC_ACTIVE;
          next_s.cpu_resume = s.from_stby;
          next_s.from_stby = 1'b0;
        end
        else
          next_s.cnt = s.cnt - 8'h01;
      end
      PMC_SHUTDOWN:
      begin
        // Compare against the level seen at entry, not last cycle
        next_s.pin_prev = s.pin_prev;
        if (pin_hit(pin_now, s.pin_prev, shut_wake_en))
        begin
          next_s.mode = PMC_ACTIVE;
          next_s.sys_reset = 1'b1;
          next_s.cause = PMC_CAUSE_SHUTWAKE;
          next_s.jtag_4pin = 1'b0;
        end
      end
      PMC_HELD:
      begin
        next_s.mode = PMC_HELD;
      end
      default:
      begin
        next_s.mode = PMC_ACTIVE;
      end
    endcase

    // Reset pin wins in every mode, held included
    if (!rstpin_n_s)
    begin
      next_s.mode = PMC_ACTIVE;
      next_s.sys_reset = 1'b1;
      next_s.cause = PMC_CAUSE_PIN;
      next_s.jtag_4pin = 1'b0;
      next_s.from_stby = 1'b0;
    end

    // Domain gating from the mode being entered
    next_s.cpu_clk_en = next_s.mode == PMC_ACTIVE;
    next_s.mem_clk_en = next_s.mode == PMC_ACTIVE;
    next_s.flash_on = (next_s.mode == PMC_ACTIVE) || (next_s.mode == PMC_IDLE) ||
                      (next_s.mode == PMC_WAKE) || (next_s.mode == PMC_ENTER);
    next_s.sram_on = next_s.flash_on;
    next_s.sram_ret = next_s.mode == PMC_STANDBY;
    next_s.radio_avail = next_s.flash_on;
    next_s.periph_clk_en = next_s.flash_on;
    next_s.aon_on = (next_s.mode != PMC_SHUTDOWN) && (next_s.mode != PMC_HELD);
    next_s.sc_on = next_s.aon_on;

    // Clock enables and sources
    next_s.hf_on = next_s.flash_on;
    next_s.hf_xtal = next_s.hf_on && hf_xtal_en;
    next_s.mf_on = next_s.aon_on;
    lf_run = next_s.aon_on;
    next_s.lf_on = lf_run;
    // External input takes priority, then crystal, then RC
    if (lf_ext_sel)
      next_s.lf_src = PMC_LF_EXT;
    else if (lf_xtal_use)
      next_s.lf_src = PMC_LF_XTAL;
    else
      next_s.lf_src = PMC_LF_RC;
    next_s.rtc_comp = lf_run && (next_s.lf_src == PMC_LF_RC);
    next_s.lf_out = lf_run && lf_clk_out_req && (next_s.lf_src != PMC_LF_EXT);

    // Pad latch holds the entry value through standby and shutdown
    next_s.io_latch = (next_s.mode == PMC_STANDBY) ||
                      (next_s.mode == PMC_SHUTDOWN);
    next_s.pad = next_s.io_latch ? s.hold_val : gpio_out;

    // Host link live with the peripherals; coprocessor ownership follows cpu_sc_take in every mode
    next_s.host_spi = next_s.flash_on && network_coprocessor_role && !host_uart_sel;
    next_s.host_uart = next_s.flash_on && network_coprocessor_role && host_uart_sel;
    next_s.sc_by_cpu = cpu_sc_take;
  end

  // ********************************
  // Registers
  // ********************************
  // All outputs low in reset; active gating appears one edge later
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      s <= '0;
    else if (clk_en)
      s <= next_s;
  end

  // ********************************
  // Outputs
  // ********************************
  assign cur_mode = s.mode;
  assign mode_ack = s.mode_ack;
  assign cpu_resume = s.cpu_resume;
  assign sys_reset = s.sys_reset;
  assign reset_cause = s.cause;
  assign cpu_clk_en = s.cpu_clk_en;
  assign mem_clk_en = s.mem_clk_en;
  assign flash_on = s.flash_on;
  assign sram_on = s.sram_on;
  assign sram_ret = s.sram_ret;
  assign radio_avail = s.radio_avail;
  assign periph_clk_en = s.periph_clk_en;
  assign always_on_domain = s.aon_on;
  assign sc_on = s.sc_on;
  assign high_speed_sys_clock = s.hf_on;
  assign hf_src_xtal = s.hf_xtal;
  assign medium_speed_sys_clock = s.mf_on;
  assign low_speed_sys_clock = s.lf_on;
  assign lf_src = s.lf_src;
  assign rtc_comp_en = s.rtc_comp;
  assign lf_clk_out_en = s.lf_out;
  assign io_latch = s.io_latch;
  assign pad_out = s.pad;
  assign jtag_4pin = s.jtag_4pin;
  assign host_spi_en = s.host_spi;
  assign host_uart_en = s.host_uart;
  assign sc_periph_by_cpu = s.sc_by_cpu;

endmodule : pmc_ctrl

// file: design/pmc_sync.sv
// Two-stage synchroniser for inputs from outside the core clock
`timescale 1ns/1ns
module pmc_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and control
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pmc_sync_st_t;

  pmc_sync_st_t s;
  pmc_sync_st_t next_s;

  // First stage feeds only the second stage
  always_comb
  begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  // Register the copy
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      s <= '{meta: RST_VAL, stable: RST_VAL};
    else if (clk_en)
      s <= next_s;
  end

  assign sync_out = s.stable;

endmodule : pmc_sync

// file: dv/pmc_ctrl_monitor.sv
// Checker of mode sequencing, gating, wake and reset cause
`timescale 1ns/1ns
module pmc_ctrl_monitor
  import pmc_pkg::*;
#(
  parameter int NPIN = 8
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Requests, events and config
  input wire logic mode_req,
  input wire pmc_mode_t mode_req_sel,
  input wire logic irq_event,
  input wire logic reset_pin_n,
  input wire logic hf_xtal_en,
  input wire logic jtag_cfg_wr,
  input wire logic jtag_4pin_sel,
  // Status, gating and clocks
  input wire pmc_mode_t cur_mode,
  input wire logic mode_ack,
  input wire logic sys_reset,
  input wire pmc_cause_t reset_cause,
  input wire logic cpu_clk_en,
  input wire logic high_speed_sys_clock,
  input wire logic hf_src_xtal,
  input wire logic medium_speed_sys_clock,
  input wire logic low_speed_sys_clock,
  input wire logic always_on_domain,
  input wire logic sc_on,
  input wire logic io_latch,
  input wire logic [NPIN-1:0] pad_out,
  input wire logic jtag_4pin
);
  // ********
  // Properties
  // ********
  // Frozen clock enable would stretch every count, so it disables checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n || !clk_en);

  a_ack_six_edges:
  assert property (mode_req && reset_pin_n && cur_mode == PMC_ACTIVE &&
    mode_req_sel inside {PMC_IDLE, PMC_STANDBY, PMC_SHUTDOWN, PMC_HELD}
    |-> ##6 mode_ack && cur_mode == $past(mode_req_sel, 6))
    else $error("mode ack late or wrong mode");
  a_cpu_only_active:
  assert property (cpu_clk_en |-> cur_mode == PMC_ACTIVE)
    else $error("cpu clock outside active");
  a_idle_wake_time:
  assert property (cur_mode == PMC_IDLE && irq_event && reset_pin_n |-> ##[1:140] cpu_clk_en)
    else $error("idle wake too slow");
  a_standby_pads:
  assert property (cur_mode == PMC_STANDBY && $past(cur_mode) == PMC_STANDBY
    |-> io_latch && $stable(pad_out))
    else $error("pads moved in standby");
  a_standby_clocks:
  assert property (cur_mode == PMC_STANDBY
    |-> !high_speed_sys_clock && low_speed_sys_clock && always_on_domain)
    else $error("standby clocks wrong");
  a_deep_all_off:
  assert property (cur_mode inside {PMC_SHUTDOWN, PMC_HELD} |-> !(always_on_domain ||
    sc_on || low_speed_sys_clock || medium_speed_sys_clock || high_speed_sys_clock))
    else $error("domain on in deep mode");
  a_held_stays:
  assert property (cur_mode == PMC_HELD && reset_pin_n && $past(reset_pin_n) &&
    $past(reset_pin_n, 2) |=> cur_mode == PMC_HELD)
    else $error("held left without button");
  a_pin_cause:
  assert property ($fell(reset_pin_n) |-> ##[1:4] sys_reset && reset_cause == PMC_CAUSE_PIN)
    else $error("reset pin not reported");
  a_jtag_boot:
  assert property (!$past(rst_n) |-> !jtag_4pin)
    else $error("debug port not compact at boot");
  a_jtag_write:
  assert property (jtag_cfg_wr && cur_mode == PMC_ACTIVE |=> jtag_4pin == $past(jtag_4pin_sel))
    else $error("debug port mode not loaded");
  a_hf_source:
  assert property (high_speed_sys_clock && $past(high_speed_sys_clock)
    |-> hf_src_xtal == $past(hf_xtal_en))
    else $error("high clock source wrong");

  // Main scenarios reached
  c_idle_wake: cover property (cur_mode == PMC_IDLE ##1 cur_mode == PMC_WAKE);
  c_standby: cover property (mode_ack && cur_mode == PMC_STANDBY);
  c_shut_wake: cover property (sys_reset && reset_cause == PMC_CAUSE_SHUTWAKE);
endmodule : pmc_ctrl_monitor

bind pmc_ctrl pmc_ctrl_monitor #(.NPIN(NPIN)) pmc_ctrl_monitor_i (
  .core_clk, .rst_n, .clk_en, .mode_req, .mode_req_sel, .irq_event, .reset_pin_n,
  .hf_xtal_en, .jtag_cfg_wr, .jtag_4pin_sel, .cur_mode, .mode_ack, .sys_reset,
  .reset_cause, .cpu_clk_en, .high_speed_sys_clock, .hf_src_xtal, .medium_speed_sys_clock,
  .low_speed_sys_clock, .always_on_domain, .sc_on, .io_latch, .pad_out, .jtag_4pin
);

// file: dv/pmc_far_side.sv
// Model of wake pins, timer, coprocessor and reset button
`timescale 1ns/1ns
module pmc_far_side
#(
  parameter int NPIN = 8
)
(
  // Clock the model steps on
  input wire logic core_clk,
  // Wake sources seen by the controller
  output logic rtc_event,
  output logic sc_event,
  output logic reset_pin_n,
  output logic [NPIN-1:0] wake_pin
);
  // ********
  // Sources
  // ********
  // All quiet and the button released at time zero
  initial
  begin
    rtc_event = 1'b0;
    sc_event = 1'b0;
    reset_pin_n = 1'b1;
    wake_pin = '0;
  end

  // Held three edges so the two-stage synchroniser cannot miss it
  task automatic wake(input int src);
    @(posedge core_clk);
    if (src >= 2)
      wake_pin[src-2] <= ~wake_pin[src-2];
    else if (src == 1)
      sc_event <= 1'b1;
    else
      rtc_event <= 1'b1;
    repeat (3) @(posedge core_clk);
    rtc_event <= 1'b0;
    sc_event <= 1'b0;
  endtask : wake

  // Button held low for n edges
  task automatic press(input int n);
    @(posedge core_clk);
    reset_pin_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    reset_pin_n <= 1'b1;
  endtask : press
endmodule : pmc_far_side

// file: dv/tb_power_mode_controller.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
module tb_power_mode_controller
  import pmc_pkg::*;
;
  // ********
  // Signals
  // ********
  localparam int NPIN = 8;
  logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, mode_req = 1'b0, irq_event = 1'b0;
  logic jtag_cfg_wr = 1'b0, jtag_4pin_sel = 1'b0, hf_xtal_en = 1'b0, lf_xtal_use = 1'b0;
  logic lf_ext_sel = 1'b0, lf_clk_out_req = 1'b0, network_coprocessor_role = 1'b0;
  logic host_uart_sel = 1'b0, cpu_sc_take = 1'b0;
  logic [NPIN-1:0] pin_wake_en = '0, shut_wake_en = '0, gpio_out = '0;
  pmc_mode_t mode_req_sel = PMC_IDLE;
  logic rtc_event, sc_event, reset_pin_n;
  logic [NPIN-1:0] wake_pin, pad_out;
  pmc_mode_t cur_mode;
  pmc_cause_t reset_cause;
  pmc_lf_src_t lf_src;
  logic mode_ack, cpu_resume, sys_reset, cpu_clk_en, mem_clk_en, flash_on, sram_on, sram_ret;
  logic radio_avail, periph_clk_en, always_on_domain, sc_on, high_speed_sys_clock;
  logic hf_src_xtal, medium_speed_sys_clock, low_speed_sys_clock, rtc_comp_en, lf_clk_out_en;
  logic io_latch, jtag_4pin, host_spi_en, host_uart_en, sc_periph_by_cpu;
  int miscompares = 0;
  int compares = 0;

  pmc_ctrl #(.NPIN(NPIN)) pmc_ctrl_i (
    .core_clk, .rst_n, .clk_en, .mode_req, .mode_req_sel, .irq_event, .rtc_event, .sc_event,
    .reset_pin_n, .wake_pin, .pin_wake_en, .shut_wake_en, .gpio_out, .jtag_cfg_wr,
    .jtag_4pin_sel, .hf_xtal_en, .lf_xtal_use, .lf_ext_sel, .lf_clk_out_req,
    .network_coprocessor_role, .host_uart_sel, .cpu_sc_take, .cur_mode, .mode_ack,
    .cpu_resume, .sys_reset, .reset_cause, .cpu_clk_en, .mem_clk_en, .flash_on, .sram_on,
    .sram_ret, .radio_avail, .periph_clk_en, .always_on_domain, .sc_on,
    .high_speed_sys_clock, .hf_src_xtal, .medium_speed_sys_clock, .low_speed_sys_clock,
    .lf_src, .rtc_comp_en, .lf_clk_out_en, .io_latch, .pad_out, .jtag_4pin, .host_spi_en,
    .host_uart_en, .sc_periph_by_cpu
  );
  pmc_far_side #(.NPIN(NPIN)) pmc_far_side_i (
    .core_clk, .rtc_event, .sc_event, .reset_pin_n, .wake_pin
  );

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // ********
  // Helpers
  // ********
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (miscompares == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // Look 1 ns after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Bounded wait for reset pulse or cpu clock; looks at the current edge first
  // One-cycle pulses launched by the edge just passed would otherwise be missed
  task automatic wait_for(input bit rst_flag, output int n);
    n = 0;
    #1;
    while ((rst_flag ? sys_reset : cpu_clk_en) !== 1'b1 && n < 200)
    begin
      tick(1);
      n++;
    end
  endtask : wait_for

  // One request pulse; ack launched by the fifth edge after the taking edge
  // It is therefore sampled high at the sixth edge
  task automatic go(input pmc_mode_t sel);
    int n;
    @(posedge core_clk);
    mode_req <= 1'b1;
    mode_req_sel <= sel;
    @(posedge core_clk);
    mode_req <= 1'b0;
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (mode_ack !== 1'b1 && n < 20);
    chk("ack_edges", n, 5);
    chk("mode", cur_mode, sel);
  endtask : go

  // ********
  // Scenarios
  // ********
  task automatic t_boot();
    chk("jtag_boot", jtag_4pin, 0);
    chk("cause_por", reset_cause, PMC_CAUSE_POR);
    chk("active_up", {cpu_clk_en, flash_on, sram_on, radio_avail, periph_clk_en}, 8'h1f);
    @(posedge core_clk);
    jtag_4pin_sel <= 1'b1;
    jtag_cfg_wr <= 1'b1;
    @(posedge core_clk);
    jtag_cfg_wr <= 1'b0;
    tick(1);
    chk("jtag_4pin", jtag_4pin, 1);
  endtask : t_boot

  // Rows: internal low RC, external low clock, low crystal
  task automatic t_clk();
    logic [4:0] exp [3] = '{5'h1e, 5'h01, 5'h15};
    @(posedge core_clk);
    lf_clk_out_req <= 1'b1;
    network_coprocessor_role <= 1'b1;
    cpu_sc_take <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge core_clk);
      lf_ext_sel <= (i == 1);
      lf_xtal_use <= (i == 2);
      host_uart_sel <= (i == 0);
      hf_xtal_en <= (i != 1);
      tick(2);
      chk("lf_src", lf_src, i == 1 ? PMC_LF_EXT : i == 2 ? PMC_LF_XTAL : PMC_LF_RC);
      chk("clk_host", {hf_src_xtal, rtc_comp_en, lf_clk_out_en, host_uart_en, host_spi_en},
        exp[i]);
    end
    chk("sc_by_cpu", sc_periph_by_cpu, 1);
  endtask : t_clk

  task automatic t_idle();
    int n;
    go(PMC_IDLE);
    chk("idle_gate", {cpu_clk_en, mem_clk_en, periph_clk_en, flash_on}, 8'h3);
    // Clock enable low freezes idle even with the interrupt up
    @(posedge core_clk);
    clk_en <= 1'b0;
    irq_event <= 1'b1;
    tick(3);
    chk("idle_frozen", cur_mode, PMC_IDLE);
    @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    irq_event <= 1'b0;
    wait_for(1'b0, n);
    chk("idle_wake", n <= 140, 1);
    chk("idle_back", cur_mode, PMC_ACTIVE);
  endtask : t_idle

  // Timer, coprocessor and pin each wake standby; an interrupt must not
  task automatic t_standby();
    int n;
    for (int s = 0; s < 3; s++)
    begin
      @(posedge core_clk);
      gpio_out <= 8'h5a;
      pin_wake_en <= 8'h01;
      go(PMC_STANDBY);
      @(posedge core_clk);
      gpio_out <= 8'ha5;
      irq_event <= 1'b1;
      @(posedge core_clk);
      irq_event <= 1'b0;
      tick(4);
      chk("pads_held", pad_out, 8'h5a);
      chk("sb_irq", cur_mode, PMC_STANDBY);
      chk("sb_dom", {high_speed_sys_clock, medium_speed_sys_clock, low_speed_sys_clock,
        sram_ret, radio_avail}, 8'h0e);
      pmc_far_side_i.wake(s);
      wait_for(1'b0, n);
      chk("sb_resume", cpu_resume, 1);
      tick(2);
      chk("pads_free", pad_out, 8'ha5);
    end
  endtask : t_standby

  task automatic t_shut();
    int n;
    @(posedge core_clk);
    shut_wake_en <= 8'h02;
    go(PMC_SHUTDOWN);
    chk("sd_off", {always_on_domain, sc_on, low_speed_sys_clock, io_latch}, 8'h1);
    chk("sd_pads", pad_out, 8'ha5);
    pmc_far_side_i.wake(0);
    tick(4);
    chk("sd_no_rtc", cur_mode, PMC_SHUTDOWN);
    pmc_far_side_i.wake(3);
    wait_for(1'b1, n);
    chk("sd_reset", n, 0);
    chk("sd_cause", reset_cause, PMC_CAUSE_SHUTWAKE);
    chk("sd_mode", cur_mode, PMC_ACTIVE);
    chk("sd_jtag", jtag_4pin, 0);
  endtask : t_shut

  // Pin edges are ignored in held; only the button leaves it
  task automatic t_held();
    go(PMC_HELD);
    pmc_far_side_i.wake(2);
    tick(6);
    chk("held_stay", cur_mode, PMC_HELD);
    pmc_far_side_i.press(4);
    tick(1);
    chk("pin_rst", {sys_reset, reset_cause}, 8'h5);
    tick(6);
    chk("pin_mode", {sys_reset, cur_mode}, PMC_ACTIVE);
  endtask : t_held

  // ********
  // Main
  // ********
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    tick(3);
    t_boot();
    t_clk();
    t_idle();
    t_standby();
    t_shut();
    t_held();
    stop_test();
  end

  // Whole run is a few hundred cycles; 5000 means a hang
  initial
  begin
    #(5000 * 100);
    miscompares++;
    stop_test();
  end
endmodule : tb_power_mode_controller

// file: pkg/pmc_map.svh
// Timing counts and fixed figures of the power mode controller
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// Core clock period in ns
`define PMC_CLK_PERIOD_NS 100
// Longest idle to executing CPU time in ns
`define PMC_IDLE_WAKE_NS 14000
// Longest idle wake in cycles, rounded down
`define PMC_IDLE_WAKE_MAX_CYC ((`PMC_IDLE_WAKE_NS) / (`PMC_CLK_PERIOD_NS))
// Counter width for gating and restart sequences
`define PMC_CNT_W 8
// Cycles spent with CPU and memory clocks gated before the ack and domain power-down
`define PMC_GATE_CYC 8'h04
// Cycles spent restarting clocks on a wake, well under the idle limit
`define PMC_RESTART_CYC 8'h08
// Count value at which a sequence step ends
`define PMC_CNT_DONE 8'h00

`endif

// file: pkg/pmc_pkg.sv
// Types shared by the power mode controller files
package pmc_pkg;

  // Gray coded along active, enter, idle, wake, standby, shutdown, held
  typedef enum logic [2:0] {
    PMC_ACTIVE   = 3'h0,
    PMC_ENTER    = 3'h1,
    PMC_IDLE     = 3'h3,
    PMC_WAKE     = 3'h2,
    PMC_STANDBY  = 3'h6,
    PMC_SHUTDOWN = 3'h7,
    PMC_HELD     = 3'h5
  } pmc_mode_t;

  // Cause of the last reset
  typedef enum logic [1:0] {
    PMC_CAUSE_POR      = 2'h0,
    PMC_CAUSE_PIN      = 2'h1,
    PMC_CAUSE_SHUTWAKE = 2'h2
  } pmc_cause_t;

  // Source of the low-speed system clock
  typedef enum logic [1:0] {
    PMC_LF_XTAL = 2'h0,
    PMC_LF_RC   = 2'h1,
    PMC_LF_EXT  = 2'h2
  } pmc_lf_src_t;

endpackage : pmc_pkg
